// ==== rtl/rom_access_device.sv ====
// store controller: address, data and control registers, page buffer and cycle timer
//
// Overview of operation
// - 4096 bytes, 12-bit address, not data-mapped
// - low address register, bits 7..0, reset zero
// - high address bits 11..8, upper nibble zero
// - address writes only while page mode clear
// - data register holds fetched byte until next cycle
// - control bit 4 selects byte or page
// - write enable clear inhibits every program
// - write start needs enable; hardware clears it
// - fetch enable clear inhibits every read
// - read start needs enable; cleared when byte ready
// - software never sets enables with starts together
// - software read sequence: address, enable, start, poll
// - direct registers decode in any bank; control at 40h bank 1
// - control bits 7..5 zero; all reset zero
// - page load bumps low 5 bits, saturating
// - buffer cleared at reset and enable fall
// - write end sets done flag; software clears
`timescale 1ns/1ps
module rom_access_device
#(
  parameter int WRITE_CYCLES = rom_access_pkg::WRITE_CYCLES_DEF,
  parameter int READ_CYCLES  = rom_access_pkg::READ_CYCLES_DEF
)(
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  rom_bus_if.device_mp     bus,
  output logic             done_irq_out,
  output logic             busy_out
);
  import rom_access_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_WRITE, D_READ, D_LATCH} dev_state_t;

  typedef struct packed {
    dev_state_t                        st;
    logic [DATA_W-1:0]                 addr_lo;
    logic [AH_W-1:0]                   addr_hi;
    logic [DATA_W-1:0]                 data;
    logic                              page_mode_sel;
    logic                              program_enable;
    logic                              wr_start;
    logic                              fetch_enable;
    logic                              rd_start;
    logic                              done_irq_flag;
    logic [CNT_W-1:0]                  cnt;
    logic [PAGE_BYTES-1:0][DATA_W-1:0] pbuf;
    logic [PAGE_BYTES-1:0]             pvalid;
    logic [DATA_W-1:0]                 rdata;
    logic                              busy;
  } dev_t;

  localparam logic [CNT_W-1:0]      WR_LOAD  = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [CNT_W-1:0]      RD_LOAD  = CNT_W'(READ_CYCLES - 1);
  localparam logic [CNT_W-1:0]      CNT_ZERO = '0;
  localparam logic [PAGE_IDX_W-1:0] IDX_LAST = PAGE_IDX_W'(PAGE_BYTES - 1);
  localparam logic [PAGE_IDX_W-1:0] IDX_ZERO = '0;

  dev_t                   q;
  dev_t                   d;
  logic                   mem_wr_byte;
  logic                   mem_wr_page;
  logic                   mem_rd;
  logic [DATA_W-1:0]      mem_rdata;
  logic [ADDR_W-1:0]      full_addr;
  logic [PAGE_IDX_W-1:0]  idx;

  // ----------------------------------------------------------------
  // cell array hookup
  // ----------------------------------------------------------------
  assign full_addr   = {q.addr_hi, q.addr_lo};
  assign idx         = q.addr_lo[PAGE_IDX_W-1:0];
  assign mem_wr_byte = (q.st == D_WRITE) && (q.cnt == CNT_ZERO)
                       && q.program_enable && !q.page_mode_sel;
  assign mem_wr_page = (q.st == D_WRITE) && (q.cnt == CNT_ZERO)
                       && q.program_enable && q.page_mode_sel;
  assign mem_rd      = (q.st == D_READ) && (q.cnt == CNT_ZERO) && q.fetch_enable;

  rom_cell_array #(
    .AW (ADDR_W),
    .PB (PAGE_BYTES)
  ) cells (
    .clk_sys_in (clk_sys_in),
    .wr_byte_in (mem_wr_byte),
    .wr_page_in (mem_wr_page),
    .rd_in      (mem_rd),
    .addr_in    (full_addr),
    .wdata_in   (q.data),
    .page_in    (q.pbuf),
    .mask_in    (q.pvalid),
    .rdata_out  (mem_rdata)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // register writes
    if (bus.wr)
    begin
      if (reg_hit(bus.bank, bus.ofs, OFS_ADDR_LO, 1'b0) && !q.page_mode_sel)
      begin
        d.addr_lo = bus.wdata;
      end
      if (reg_hit(bus.bank, bus.ofs, OFS_ADDR_HI, 1'b0) && !q.page_mode_sel)
      begin
        d.addr_hi = bus.wdata[AH_W-1:0];
      end
      if (reg_hit(bus.bank, bus.ofs, OFS_DATA, 1'b0))
      begin
        d.data = bus.wdata;
        if (q.page_mode_sel)
        begin
          d.pbuf[idx]   = bus.wdata;
          d.pvalid[idx] = 1'b1;
          if (idx != IDX_LAST)
          begin
            d.addr_lo[PAGE_IDX_W-1:0] = idx + 1'b1;
          end
        end
      end
      if (reg_hit(bus.bank, bus.ofs, OFS_DONE, 1'b0) && !bus.wdata[DONE_BIT])
      begin
        d.done_irq_flag = 1'b0;
      end
      if (reg_hit(bus.bank, bus.ofs, OFS_CTRL, 1'b1))
      begin
        d.page_mode_sel  = bus.wdata[CB_PAGE];
        d.program_enable = bus.wdata[CB_PROG];
        d.fetch_enable   = bus.wdata[CB_FETCH];
        if (q.st == D_IDLE)
        begin
          if (bus.wdata[CB_WSTART] && q.program_enable)
          begin
            d.wr_start = 1'b1;
            d.st       = D_WRITE;
            d.cnt      = WR_LOAD;
          end
          else if (bus.wdata[CB_RSTART] && q.fetch_enable)
          begin
            d.rd_start = 1'b1;
            d.st       = D_READ;
            d.cnt      = RD_LOAD;
          end
        end
      end
    end
    // page buffer flush on enable fall
    if (q.program_enable && !d.program_enable)
    begin
      d.pbuf   = '0;
      d.pvalid = '0;
    end
    // cycle sequencing
    case (q.st)
      D_IDLE:
      begin
        d.cnt = d.cnt;
      end
      D_WRITE:
      begin
        if (q.cnt == CNT_ZERO)
        begin
          d.wr_start      = 1'b0;
          d.done_irq_flag = 1'b1;
          d.st            = D_IDLE;
          if (q.page_mode_sel)
          begin
            d.addr_lo[PAGE_IDX_W-1:0] = IDX_ZERO;
            d.pvalid                  = '0;
          end
        end
        else
        begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      D_READ:
      begin
        if (q.cnt == CNT_ZERO)
        begin
          d.st = D_LATCH;
        end
        else
        begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      D_LATCH:
      begin
        if (q.fetch_enable)
        begin
          d.data = mem_rdata;
        end
        d.rd_start = 1'b0;
        d.st       = D_IDLE;
      end
      default:
      begin
        d.st = D_IDLE;
      end
    endcase
    d.busy = (d.st != D_IDLE);
    // register reads
    if (bus.rd)
    begin
      if (reg_hit(bus.bank, bus.ofs, OFS_ADDR_LO, 1'b0))
      begin
        d.rdata = q.addr_lo;
      end
      else if (reg_hit(bus.bank, bus.ofs, OFS_ADDR_HI, 1'b0))
      begin
        d.rdata = {{(DATA_W-AH_W){1'b0}}, q.addr_hi};
      end
      else if (reg_hit(bus.bank, bus.ofs, OFS_DATA, 1'b0))
      begin
        d.rdata = q.data;
      end
      else if (reg_hit(bus.bank, bus.ofs, OFS_DONE, 1'b0))
      begin
        d.rdata = {{(DATA_W-1){1'b0}}, q.done_irq_flag};
      end
      else if (reg_hit(bus.bank, bus.ofs, OFS_CTRL, 1'b1))
      begin
        d.rdata = {3'h0, q.page_mode_sel, q.program_enable, q.wr_start,
                   q.fetch_enable, q.rd_start};
      end
      else
      begin
        d.rdata = BYTE_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.rdata    = q.rdata;
  assign done_irq_out = q.done_irq_flag;
  assign busy_out     = q.busy;
endmodule

// ==== rtl/rom_access_pkg.sv ====
// shared constants, register map and helpers for the nonvolatile store access path
package rom_access_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 8;
  localparam int AH_W       = 4;
  localparam int BANK_W     = 3;
  localparam int OFS_W      = 8;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_IDX_W = 5;
  localparam int CNT_W      = 20;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [OFS_W-1:0]  OFS_ADDR_LO = 8'h2a;
  localparam logic [OFS_W-1:0]  OFS_ADDR_HI = 8'h2b;
  localparam logic [OFS_W-1:0]  OFS_DATA    = 8'h2c;
  localparam logic [OFS_W-1:0]  OFS_DONE    = 8'h2d;
  localparam logic [OFS_W-1:0]  OFS_CTRL    = 8'h40;
  localparam logic [BANK_W-1:0] BANK_DIRECT = 3'h0;
  localparam logic [BANK_W-1:0] BANK_CTRL   = 3'h1;
  localparam logic [DATA_W-1:0] BYTE_ZERO   = 8'h00;

  // ----------------------------------------------------------------
  // control and flag bit positions
  // ----------------------------------------------------------------
  localparam int CB_PAGE   = 4;
  localparam int CB_PROG   = 3;
  localparam int CB_WSTART = 2;
  localparam int CB_FETCH  = 1;
  localparam int CB_RSTART = 0;
  localparam int DONE_BIT  = 0;

  localparam logic [DATA_W-1:0] CTRL_OFF       = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_FETCH     = 8'h02;
  localparam logic [DATA_W-1:0] CTRL_FETCH_GO  = 8'h03;
  localparam logic [DATA_W-1:0] CTRL_PROG      = 8'h08;
  localparam logic [DATA_W-1:0] CTRL_PROG_GO   = 8'h0c;

  // ----------------------------------------------------------------
  // cycle timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ          = 25000;
  localparam int WRITE_TIME_US    = 2000;
  localparam int READ_TIME_NS     = 400;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_KHZ / 1000;
  localparam int READ_CYCLES_DEF  = (READ_TIME_NS * CLK_KHZ + 999999) / 1000000;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [BANK_W-1:0] bank, input logic [OFS_W-1:0] ofs,
                                   input logic [OFS_W-1:0] want, input logic indirect);
    reg_hit = (ofs == want) && (!indirect || bank == BANK_CTRL);
  endfunction

endpackage

// ==== rtl/rom_bus_if.sv ====
// register access path between the cpu side and the store controller
`timescale 1ns/1ps
interface rom_bus_if;
  import rom_access_pkg::*;

  logic [BANK_W-1:0] bank;
  logic [OFS_W-1:0]  ofs;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  modport device_mp (input bank, input ofs, input wr, input rd, input wdata, output rdata);
  modport host_mp   (output bank, output ofs, output wr, output rd, output wdata, input rdata);
endinterface

// ==== rtl/rom_cell_array.sv ====
// byte-wide nonvolatile cell array with byte and page program ports
`timescale 1ns/1ps
module rom_cell_array
#(
  parameter int AW = rom_access_pkg::ADDR_W,
  parameter int PB = rom_access_pkg::PAGE_BYTES
)(
  input  wire logic                                      clk_sys_in,
  input  wire logic                                      wr_byte_in,
  input  wire logic                                      wr_page_in,
  input  wire logic                                      rd_in,
  input  wire logic [AW-1:0]                             addr_in,
  input  wire logic [rom_access_pkg::DATA_W-1:0]         wdata_in,
  input  wire logic [PB-1:0][rom_access_pkg::DATA_W-1:0] page_in,
  input  wire logic [PB-1:0]                             mask_in,
  output logic      [rom_access_pkg::DATA_W-1:0]         rdata_out
);
  import rom_access_pkg::*;

  logic [DATA_W-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------------------------------
  // program and fetch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_byte_in)
    begin
      mem[addr_in] <= wdata_in;
    end
    if (wr_page_in)
    begin
      for (int i = 0; i < PB; i++)
      begin
        if (mask_in[i])
        begin
          mem[{addr_in[AW-1:PAGE_IDX_W], PAGE_IDX_W'(i)}] <= page_in[i];
        end
      end
    end
    if (rd_in)
    begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule

// ==== rtl/rom_access_host.sv ====
// cpu-side sequencer: runs byte read and byte write sequences over the register path
`timescale 1ns/1ps
module rom_access_host (
  input  wire logic                                clk_sys_in,
  input  wire logic                                rstn_in,
  rom_bus_if.host_mp                               bus,
  input  wire logic                                cmd_valid_in,
  input  wire logic                                cmd_write_in,
  input  wire logic [rom_access_pkg::ADDR_W-1:0]   cmd_addr_in,
  input  wire logic [rom_access_pkg::DATA_W-1:0]   cmd_data_in,
  output logic                                     cmd_ready_out,
  output logic                                     rsp_valid_out,
  output logic      [rom_access_pkg::DATA_W-1:0]   rsp_data_out
);
  import rom_access_pkg::*;

  typedef enum logic [3:0] {H_IDLE, H_MODE, H_AH, H_AL, H_DATA, H_EN, H_GO, H_POLL_A, H_POLL_B,
                            H_FETCH_A, H_FETCH_B, H_CLR, H_OFF} host_state_t;

  typedef struct packed {
    host_state_t       st;
    logic              is_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wbyte;
    logic [BANK_W-1:0] bank;
    logic [OFS_W-1:0]  ofs;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
    logic              ready;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
  } host_t;

  host_t q;
  host_t d;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    d           = q;
    d.wr        = 1'b0;
    d.rd        = 1'b0;
    d.rsp_valid = 1'b0;
    case (q.st)
      H_IDLE:
      begin
        if (cmd_valid_in)
        begin
          d.is_write = cmd_write_in;
          d.addr     = cmd_addr_in;
          d.wbyte    = cmd_data_in;
          d.ready    = 1'b0;
          {d.bank, d.ofs, d.wr, d.wdata} = {BANK_CTRL, OFS_CTRL, 1'b1, CTRL_OFF};
          d.st       = H_MODE;
        end
      end
      H_MODE:
      begin
        {d.bank, d.ofs, d.wr} = {BANK_DIRECT, OFS_ADDR_HI, 1'b1};
        d.wdata = {{(DATA_W-AH_W){1'b0}}, q.addr[ADDR_W-1:DATA_W]};
        d.st    = H_AH;
      end
      H_AH:
      begin
        {d.bank, d.ofs, d.wr, d.wdata} = {BANK_DIRECT, OFS_ADDR_LO, 1'b1, q.addr[DATA_W-1:0]};
        d.st = H_AL;
      end
      H_AL:
      begin
        if (q.is_write)
        begin
          {d.bank, d.ofs, d.wr, d.wdata} = {BANK_DIRECT, OFS_DATA, 1'b1, q.wbyte};
          d.st = H_DATA;
        end
        else
        begin
          {d.bank, d.ofs, d.wr, d.wdata} = {BANK_CTRL, OFS_CTRL, 1'b1, CTRL_FETCH};
          d.st = H_EN;
        end
      end
      H_DATA:
      begin
        {d.bank, d.ofs, d.wr, d.wdata} = {BANK_CTRL, OFS_CTRL, 1'b1, CTRL_PROG};
        d.st = H_EN;
      end
      H_EN:
      begin
        d.wdata = q.is_write ? CTRL_PROG_GO : CTRL_FETCH_GO;
        {d.bank, d.ofs, d.wr} = {BANK_CTRL, OFS_CTRL, 1'b1};
        d.st = H_GO;
      end
      H_GO, H_POLL_B:
      begin
        if (q.st == H_POLL_B && !bus.rdata[q.is_write ? CB_WSTART : CB_RSTART])
        begin
          if (q.is_write)
          begin
            {d.bank, d.ofs, d.wr, d.wdata} = {BANK_DIRECT, OFS_DONE, 1'b1, BYTE_ZERO};
            d.st = H_CLR;
          end
          else
          begin
            {d.bank, d.ofs, d.rd} = {BANK_DIRECT, OFS_DATA, 1'b1};
            d.st = H_FETCH_A;
          end
        end
        else
        begin
          {d.bank, d.ofs, d.rd} = {BANK_CTRL, OFS_CTRL, 1'b1};
          d.st = H_POLL_A;
        end
      end
      H_POLL_A:
      begin
        d.st = H_POLL_B;
      end
      H_FETCH_A:
      begin
        d.st = H_FETCH_B;
      end
      H_FETCH_B:
      begin
        d.rsp_valid = 1'b1;
        d.rsp_data  = bus.rdata;
        {d.bank, d.ofs, d.wr, d.wdata} = {BANK_CTRL, OFS_CTRL, 1'b1, CTRL_OFF};
        d.st = H_OFF;
      end
      H_CLR:
      begin
        d.rsp_valid = 1'b1;
        {d.bank, d.ofs, d.wr, d.wdata} = {BANK_CTRL, OFS_CTRL, 1'b1, CTRL_OFF};
        d.st = H_OFF;
      end
      H_OFF:
      begin
        d.bank  = BANK_DIRECT;
        d.ready = 1'b1;
        d.st    = H_IDLE;
      end
      default:
      begin
        d.st = H_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      q       <= '0;
      q.ready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus.bank      = q.bank;
  assign bus.ofs       = q.ofs;
  assign bus.wr        = q.wr;
  assign bus.rd        = q.rd;
  assign bus.wdata     = q.wdata;
  assign cmd_ready_out = q.ready;
  assign rsp_valid_out = q.rsp_valid;
  assign rsp_data_out  = q.rsp_data;
endmodule

// ==== tb/rom_access_monitor.sv ====
// assertion checker for the host-to-store register path
`timescale 1ns/1ps
module rom_access_monitor
#(
  parameter int WRITE_CYCLES = 20,
  parameter int READ_CYCLES  = 3
)(
  input wire logic                              clk_sys_in,
  input wire logic                              rstn_in,
  input wire logic [rom_access_pkg::BANK_W-1:0] bank,
  input wire logic [rom_access_pkg::OFS_W-1:0]  ofs,
  input wire logic                              wr,
  input wire logic                              rd,
  input wire logic [rom_access_pkg::DATA_W-1:0] wdata,
  input wire logic [rom_access_pkg::DATA_W-1:0] rdata,
  input wire logic                              done_irq_out,
  input wire logic                              busy_out
);
  import rom_access_pkg::*;

  localparam int W_LO = WRITE_CYCLES;
  localparam int W_HI = WRITE_CYCLES + 2;
  localparam int R_LO = READ_CYCLES + 1;
  localparam int R_HI = READ_CYCLES + 3;
  logic [DATA_W-1:0] last_q;
  logic              wkind_q;
  wire               ctrl_wr = wr && ofs == OFS_CTRL && bank == BANK_CTRL;
  wire               start_w = ctrl_wr && wdata[CB_WSTART] && last_q[CB_PROG] && !busy_out;
  wire               start_r = ctrl_wr && !wdata[CB_WSTART] && wdata[CB_RSTART] && last_q[CB_FETCH] && !busy_out;

  // ----------------------------------------------------------------
  // last control value and cycle kind
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      last_q  <= 8'h00;
      wkind_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        last_q <= wdata;
      if (start_w || start_r)
        wkind_q <= start_w;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  property p_one_start; ctrl_wr |-> !(wdata[CB_WSTART] && wdata[CB_RSTART]); endproperty
  a_one_start: assert property (p_one_start) else $error("both start bits in one write");
  property p_wstart_en; ctrl_wr && wdata[CB_WSTART] |-> last_q[CB_PROG]; endproperty
  a_wstart_en: assert property (p_wstart_en) else $error("write start without prior enable");
  property p_rstart_en; ctrl_wr && wdata[CB_RSTART] |-> last_q[CB_FETCH] && !last_q[CB_PAGE]; endproperty
  a_rstart_en: assert property (p_rstart_en) else $error("read start out of sequence");
  property p_busy_start; start_w || start_r |=> busy_out; endproperty
  a_busy_start: assert property (p_busy_start) else $error("accepted start did not raise busy");
  property p_write_len; start_w |-> ##[W_LO:W_HI] $fell(busy_out); endproperty
  a_write_len: assert property (p_write_len) else $error("write cycle length wrong");
  property p_read_len; start_r |-> ##[R_LO:R_HI] $fell(busy_out); endproperty
  a_read_len: assert property (p_read_len) else $error("read cycle length wrong");
  property p_done_set; $fell(busy_out) && wkind_q |-> done_irq_out; endproperty
  a_done_set: assert property (p_done_set) else $error("write end without done flag");
  property p_done_hold; done_irq_out && !(wr && ofs == OFS_DONE && !wdata[DONE_BIT]) |=> done_irq_out; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag dropped by itself");
  property p_ctrl_rd; rd && ofs == OFS_CTRL && bank == BANK_CTRL |=> rdata[7:5] == 3'h0; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control upper bits not zero");
  property p_rdata_hold; !rd |=> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
  c_write: cover property (start_w);
  c_read: cover property (start_r);
  c_done_clr: cover property ($fell(done_irq_out));
endmodule

// ==== tb/tb_top.sv ====
// testbench: host commands on one store controller, direct register traffic on another
`timescale 1ns/1ps
module tb_top;
  import rom_access_pkg::*;
  localparam int WC = 20;
  localparam int RC = 3;
  logic              clk_sys_in, rstn_in, cmd_valid, cmd_write, cmd_ready, rsp_valid, done_a, busy_a, done_b, busy_b;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data, rsp_data, got;
  logic [DATA_W-1:0] mdl [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] alist [$];
  logic [DATA_W-1:0] tbl [5] = '{OFS_ADDR_LO, OFS_ADDR_HI, OFS_DATA, OFS_DONE, 8'h33};
  int                err_count, n_compared, cyc, n;
  rom_bus_if if_a ();
  rom_bus_if if_b ();
  rom_access_host rom_access_host_inst (.clk_sys_in, .rstn_in, .bus(if_a), .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data));
  rom_access_device #(.WRITE_CYCLES(WC), .READ_CYCLES(RC)) rom_access_device_inst (.clk_sys_in, .rstn_in,
    .bus(if_a), .done_irq_out(done_a), .busy_out(busy_a));
  rom_access_device #(.WRITE_CYCLES(WC), .READ_CYCLES(RC)) rom_access_device_inst2 (.clk_sys_in, .rstn_in,
    .bus(if_b), .done_irq_out(done_b), .busy_out(busy_b));
  rom_access_monitor #(.WRITE_CYCLES(WC), .READ_CYCLES(RC)) rom_access_monitor_inst (.clk_sys_in, .rstn_in,
    .bank(if_a.bank), .ofs(if_a.ofs), .wr(if_a.wr), .rd(if_a.rd), .wdata(if_a.wdata), .rdata(if_a.rdata),
    .done_irq_out(done_a), .busy_out(busy_a));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // control byte as read back when no start is taken
  function automatic logic [7:0] ctrl_view(input logic [7:0] w);
    ctrl_view           = 8'h00;
    ctrl_view[CB_PAGE]  = w[CB_PAGE];
    ctrl_view[CB_PROG]  = w[CB_PROG];
    ctrl_view[CB_FETCH] = w[CB_FETCH];
  endfunction
  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic bw(input logic [BANK_W-1:0] bk, input logic [OFS_W-1:0] of, input logic [7:0] d);
    step();
    {if_b.bank, if_b.ofs, if_b.wdata, if_b.wr} = {bk, of, d, 1'b1};
    step();
    if_b.wr = 1'b0;
  endtask
  task automatic br(input logic [BANK_W-1:0] bk, input logic [OFS_W-1:0] of);
    step();
    {if_b.bank, if_b.ofs, if_b.rd} = {bk, of, 1'b1};
    step();
    if_b.rd = 1'b0;
    got = if_b.rdata;
  endtask
  task automatic poll(input int b);
    got = 8'hff;
    for (int i = 0; i < 100 && got[b] !== 1'b0; i++)
      br(BANK_CTRL, OFS_CTRL);
    chk("start_clear", 8'h00, {7'h0, got[b]});
  endtask
  task automatic set_addr(input logic [ADDR_W-1:0] a);
    bw(BANK_CTRL, OFS_CTRL, CTRL_OFF);
    bw(BANK_DIRECT, OFS_ADDR_HI, {4'h0, a[11:8]});
    bw(BANK_DIRECT, OFS_ADDR_LO, a[7:0]);
  endtask
  task automatic wbyte(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    set_addr(a);
    bw(BANK_DIRECT, OFS_DATA, d);
    bw(BANK_CTRL, OFS_CTRL, CTRL_PROG);
    bw(BANK_CTRL, OFS_CTRL, CTRL_PROG_GO);
    chk("busy", 8'h01, {7'h0, busy_b});
    poll(CB_WSTART);
    chk("done", 8'h01, {7'h0, done_b});
    bw(BANK_DIRECT, OFS_DONE, 8'h01);
    chk("done_kept", 8'h01, {7'h0, done_b});
    bw(BANK_DIRECT, OFS_DONE, 8'h00);
    chk("done_clr", 8'h00, {7'h0, done_b});
  endtask
  task automatic rbyte(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    set_addr(a);
    bw(BANK_CTRL, OFS_CTRL, CTRL_FETCH);
    bw(BANK_CTRL, OFS_CTRL, CTRL_FETCH_GO);
    poll(CB_RSTART);
    br(BANK_DIRECT, OFS_DATA);
    chk("rd_byte", exp, got);
  endtask
  task automatic hcmd(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    step();
    for (n = 0; cmd_ready !== 1'b1 && n < 100; n++)
      step();
    {cmd_valid, cmd_write, cmd_addr, cmd_data} = {1'b1, w, a, d};
    step();
    cmd_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 200; n++)
      step();
    chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
    if (!w)
      chk("rsp_data", d, rsp_data);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h58b8));
    {rstn_in, cmd_valid, cmd_write, cmd_addr, cmd_data} = '0;
    {if_b.bank, if_b.ofs, if_b.wr, if_b.rd, if_b.wdata} = '0;
    repeat (12) @(posedge clk_sys_in);
    #1;
    rstn_in = 1'b1;
    foreach (tbl[i])
    begin
      br(BANK_CTRL, tbl[i]);
      chk("reset_val", 8'h00, got);
    end
    bw(BANK_DIRECT, OFS_ADDR_HI, 8'hff);
    br(BANK_DIRECT, OFS_ADDR_HI);
    chk("addr_hi", 8'h0f, got);
    bw(BANK_DIRECT, OFS_CTRL, 8'h0a);
    br(BANK_CTRL, OFS_CTRL);
    chk("ctrl_bank0", 8'h00, got);
    bw(BANK_CTRL, OFS_CTRL, 8'hff);
    br(BANK_CTRL, OFS_CTRL);
    chk("ctrl_all", ctrl_view(8'hff), got);
    bw(BANK_DIRECT, OFS_ADDR_LO, 8'h11);
    br(BANK_DIRECT, OFS_ADDR_LO);
    chk("addr_page", 8'h00, got);
    bw(BANK_CTRL, OFS_CTRL, CTRL_OFF);
    bw(BANK_DIRECT, OFS_DATA, 8'h77);
    bw(BANK_CTRL, OFS_CTRL, 8'h05);
    br(BANK_CTRL, OFS_CTRL);
    chk("no_start", ctrl_view(8'h05), got);
    br(BANK_DIRECT, OFS_DATA);
    chk("no_enable", 8'h77, got | {busy_b, 7'h0});
    wbyte(12'h3a5, 8'h5c);
    rbyte(12'h3a5, 8'h5c);
    set_addr(12'h11e);
    bw(BANK_CTRL, OFS_CTRL, 8'h10);
    foreach (tbl[i])
      if (i < 3)
        bw(BANK_DIRECT, OFS_DATA, 8'h11 * (i + 1));
    br(BANK_DIRECT, OFS_ADDR_LO);
    chk("page_ptr", 8'h1f, got);
    bw(BANK_CTRL, OFS_CTRL, 8'h18);
    bw(BANK_CTRL, OFS_CTRL, 8'h1c);
    poll(CB_WSTART);
    br(BANK_DIRECT, OFS_ADDR_LO);
    chk("page_end", 8'h00, got);
    rbyte(12'h11e, 8'h11);
    rbyte(12'h11f, 8'h33);
    wbyte(12'h200, 8'h99);
    bw(BANK_CTRL, OFS_CTRL, 8'h18);
    bw(BANK_DIRECT, OFS_DATA, 8'h44);
    bw(BANK_CTRL, OFS_CTRL, 8'h10);
    bw(BANK_CTRL, OFS_CTRL, 8'h18);
    bw(BANK_CTRL, OFS_CTRL, 8'h1c);
    poll(CB_WSTART);
    rbyte(12'h200, 8'h99);
    alist = '{12'h000, 12'hfff};
    repeat (6) alist.push_back(12'($urandom));
    foreach (alist[i])
    begin
      mdl[alist[i]] = (i == 1) ? 8'hff : 8'($urandom);
      hcmd(1'b1, alist[i], mdl[alist[i]]);
    end
    foreach (alist[i])
      hcmd(1'b0, alist[i], mdl[alist[i]]);
    test_done();
  end
endmodule
